// ---- rtl/pac_regs.sv ----
`include "pac_defs.svh"
`default_nettype none
// How it works
// - pad enable clear turns shared pin off
// - pad enable plus always-drive drives pin continuously
// - without always-drive, release pin for foreign address
// - bias enable bit, reset one
// - sink gain 20 uA per code, reset 100
// - source gain 20 uA per code, reset 100
// - offset 5 uA per code, reset zero
// - transfer block suppresses oscillator link starts
// - calibration clock divides reference by 1/4/16/32
// - enabled pin carries matched read data, else selected source, lock default
module pac_regs
  import pac_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Asynchronous pins
  input  wire logic        crystal_reference,
  input  wire logic        lock_detect,
  // Same-clock serial port status
  input  wire logic        serial_active,
  input  wire logic        serial_addr_match,
  input  wire logic        serial_read_out,
  input  wire logic        osc_reg_write,
  input  wire logic [31:0] status_sources,
  // Shared status pin
  output var  logic        shared_status_pin_o,
  output var  logic        shared_status_pin_oe,
  // Analog controls
  output var  logic        bias_enable,
  output var  logic        high_freq_reference,
  output var  logic [6:0]  pump_sink_gain,
  output var  logic [6:0]  pump_source_gain,
  output var  logic [6:0]  pump_offset_mag,
  output var  logic        pump_offset_up_en,
  output var  logic        pump_offset_dn_en,
  output var  logic [11:0] pump_sink_ua,
  output var  logic [11:0] pump_source_ua,
  output var  logic [9:0]  pump_offset_ua,
  // Calibration controls
  output var  logic        cal_disable,
  output var  logic [2:0]  tuning_measure_interval,
  output var  logic        oscillator_serial_link_start,
  output var  logic        cal_fsm_tick,
  output var  logic        cal_interval_done
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  pac_reg_t    en_reg;
  pac_reg_t    cp_reg;
  pac_reg_t    cal_reg;
  pac_reg_t    out_reg;
  pac_reg_t    next_en_reg;
  pac_reg_t    next_cp_reg;
  pac_reg_t    next_cal_reg;
  pac_reg_t    next_out_reg;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_en;
  logic        setup;
  logic        hit;
  logic [23:0] rd_word;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;
  assign pready = 1'b1; // Zero-wait slave

  // Address decode and read mux
  always_comb begin
    hit     = 1'b1;
    rd_word = 24'h000000;
    unique case (paddr)
      `PAC_ADDR_EN:  rd_word = en_reg;
      `PAC_ADDR_CP:  rd_word = cp_reg;
      `PAC_ADDR_CAL: rd_word = cal_reg;
      `PAC_ADDR_OUT: rd_word = out_reg;
      default:       hit     = 1'b0;
    endcase
  end

  // Next register values; every bit, reserved ones too, is writable
  always_comb begin
    next_en_reg  = en_reg;
    next_cp_reg  = cp_reg;
    next_cal_reg = cal_reg;
    next_out_reg = out_reg;
    if (wr_en) begin
      unique case (paddr)
        `PAC_ADDR_EN:  next_en_reg  = pwdata[23:0];
        `PAC_ADDR_CP:  next_cp_reg  = pwdata[23:0];
        `PAC_ADDR_CAL: next_cal_reg = pwdata[23:0];
        `PAC_ADDR_OUT: next_out_reg = pwdata[23:0];
        default:       next_en_reg  = en_reg;
      endcase
    end
    // Read data and error are caught in setup so they come from flops
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_prdata  = {8'h00, rd_word};
      next_pslverr = !hit;
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg  <= `PAC_RST_EN;
      cp_reg  <= `PAC_RST_CP;
      cal_reg <= `PAC_RST_CAL;
      out_reg <= `PAC_RST_OUT;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      en_reg  <= next_en_reg;
      cp_reg  <= next_cp_reg;
      cal_reg <= next_cal_reg;
      out_reg <= next_out_reg;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ref_sync;
  logic [1:0] lock_sync;
  logic       ref_prev;
  logic [1:0] next_ref_sync;
  logic [1:0] next_lock_sync;
  logic       next_ref_prev;

  // Two stages each; the reference must run below half of pclk
  always_comb begin
    next_ref_sync  = {ref_sync[0], crystal_reference};
    next_lock_sync = {lock_sync[0], lock_detect};
    next_ref_prev  = ref_sync[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sync  <= 2'b00;
      lock_sync <= 2'b00;
      ref_prev  <= 1'b0;
    end else begin
      ref_sync  <= next_ref_sync;
      lock_sync <= next_lock_sync;
      ref_prev  <= next_ref_prev;
    end
  end

  // ----------------------------------------------------------------
  // Shared status pin
  // ----------------------------------------------------------------
  logic       pad_en;
  logic       always_drive;
  logic [4:0] src_sel;
  logic       src_bit;
  logic       next_pin_o;
  logic       next_pin_oe;

  assign pad_en       = en_reg[`PAC_EN_PAD_BIT];
  assign always_drive = out_reg[`PAC_OUT_ALWAYS_BIT];
  assign src_sel      = out_reg[`PAC_OUT_SEL_LSB +: 5];

  // Source select, then drive decision
  always_comb begin
    unique case (src_sel)
      `PAC_SRC_REGDATA: src_bit = out_reg[`PAC_OUT_DATA_BIT];
      `PAC_SRC_LOCK:    src_bit = lock_sync[1];
      default:          src_bit = status_sources[src_sel];
    endcase
    // A matched read owns the pin; otherwise the chosen source shows
    next_pin_o  = (serial_active && serial_addr_match) ? serial_read_out : src_bit;
    next_pin_oe = 1'b0;
    if (pad_en) begin
      if (always_drive) begin
        next_pin_oe = 1'b1;
      end else begin
        next_pin_oe = !(serial_active && !serial_addr_match);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_status_pin_o  <= 1'b0;
      shared_status_pin_oe <= 1'b0;
    end else begin
      shared_status_pin_o  <= next_pin_o;
      shared_status_pin_oe <= next_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // Analog field outputs
  // ----------------------------------------------------------------
  logic        next_start;
  logic [11:0] next_sink_ua;
  logic [11:0] next_source_ua;
  logic [9:0]  next_offset_ua;

  // Field decode and scaled current readouts
  always_comb begin
    bias_enable             = en_reg[`PAC_EN_BIAS_BIT];
    high_freq_reference     = en_reg[`PAC_EN_HFREF_BIT];
    pump_sink_gain          = cp_reg[`PAC_CP_SINK_LSB +: 7];
    pump_source_gain        = cp_reg[`PAC_CP_SOURCE_LSB +: 7];
    pump_offset_mag         = cp_reg[`PAC_CP_OFFSET_LSB +: 7];
    pump_offset_up_en       = cp_reg[`PAC_CP_OFS_UP_BIT];
    pump_offset_dn_en       = cp_reg[`PAC_CP_OFS_DN_BIT];
    cal_disable             = cal_reg[`PAC_CAL_DISABLE_BIT];
    tuning_measure_interval = cal_reg[`PAC_CAL_RES_LSB +: 3];
    next_sink_ua   = {5'h00, next_cp_reg[`PAC_CP_SINK_LSB +: 7]} * `PAC_GAIN_STEP_UA;
    next_source_ua = {5'h00, next_cp_reg[`PAC_CP_SOURCE_LSB +: 7]} * `PAC_GAIN_STEP_UA;
    next_offset_ua = {3'h0, next_cp_reg[`PAC_CP_OFFSET_LSB +: 7]} * `PAC_OFFSET_STEP_UA;
    next_start     = osc_reg_write && !cal_reg[`PAC_CAL_NOXFER_BIT];
  end

  // Currents track the register in the same cycle it updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_sink_ua                 <= 12'h7D0;
      pump_source_ua               <= 12'h7D0;
      pump_offset_ua               <= 10'h000;
      oscillator_serial_link_start <= 1'b0;
    end else begin
      pump_sink_ua                 <= next_sink_ua;
      pump_source_ua               <= next_source_ua;
      pump_offset_ua               <= next_offset_ua;
      oscillator_serial_link_start <= next_start;
    end
  end

  // ----------------------------------------------------------------
  // Calibration timer
  // ----------------------------------------------------------------
  pac_cal_if cal_link ();

  assign cal_link.ref_tick   = ref_sync[1] && !ref_prev;
  assign cal_link.clk_sel    = cal_reg[`PAC_CAL_CLKSEL_LSB +: 2];
  assign cal_link.resolution = cal_reg[`PAC_CAL_RES_LSB +: 3];
  assign cal_fsm_tick        = cal_link.fsm_tick;
  assign cal_interval_done   = cal_link.interval_done;

  pac_cal_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .cal     (cal_link.timer)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pad_off_a: assert property (!pad_en |=> !shared_status_pin_oe)
    else $error("shared pin driven while pad disabled");
  always_drive_a: assert property (pad_en && always_drive |=> shared_status_pin_oe)
    else $error("shared pin not driven in always-drive mode");
  foreign_release_a: assert property (
    pad_en && !always_drive && serial_active && !serial_addr_match
    |=> !shared_status_pin_oe)
    else $error("shared pin held during foreign transaction");
  bias_reset_a: assert property ($rose(presetn) |-> bias_enable)
    else $error("bias enable not on after reset");
  sink_scale_a: assert property (pump_sink_ua == 12'(pump_sink_gain) * 12'd20)
    else $error("sink current scale wrong");
  source_scale_a: assert property (pump_source_ua == 12'(pump_source_gain) * 12'd20)
    else $error("source current scale wrong");
  offset_scale_a: assert property (pump_offset_ua == 10'(pump_offset_mag) * 10'd5)
    else $error("offset current scale wrong");
  xfer_block_a: assert property (
    osc_reg_write && cal_reg[12] |=> !oscillator_serial_link_start)
    else $error("oscillator link started while blocked");
  lock_route_a: assert property (
    src_sel == 5'h01 && !serial_active ##1 $stable(src_sel)
    |-> shared_status_pin_o == $past(lock_sync[1]))
    else $error("lock indication not routed to shared pin");
  write_read_a: assert property (
    wr_en && paddr == 8'h24 |=> cp_reg == $past(pwdata[23:0]))
    else $error("written charge pump value not held");

endmodule
`default_nettype wire

// ---- common/pac_defs.svh ----
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define PAC_IDX_EN           6'h08
`define PAC_IDX_CP           6'h09
`define PAC_IDX_CAL          6'h0A
`define PAC_IDX_OUT          6'h0F
`define PAC_ADDR_EN          ({`PAC_IDX_EN, 2'b00})
`define PAC_ADDR_CP          ({`PAC_IDX_CP, 2'b00})
`define PAC_ADDR_CAL         ({`PAC_IDX_CAL, 2'b00})
`define PAC_ADDR_OUT         ({`PAC_IDX_OUT, 2'b00})

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PAC_RST_EN           24'hC1BEFF
`define PAC_RST_CP           24'h403264
`define PAC_RST_CAL          24'h002205
`define PAC_RST_OUT          24'h000001

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PAC_EN_PAD_BIT       5
`define PAC_EN_BIAS_BIT      10
`define PAC_EN_HFREF_BIT     21
`define PAC_CP_SINK_LSB      0
`define PAC_CP_SOURCE_LSB    7
`define PAC_CP_OFFSET_LSB    14
`define PAC_CP_OFS_UP_BIT    21
`define PAC_CP_OFS_DN_BIT    22
`define PAC_CAL_RES_LSB      0
`define PAC_CAL_DISABLE_BIT  11
`define PAC_CAL_NOXFER_BIT   12
`define PAC_CAL_CLKSEL_LSB   13
`define PAC_OUT_SEL_LSB      0
`define PAC_OUT_DATA_BIT     5
`define PAC_OUT_ALWAYS_BIT   7

// ----------------------------------------------------------------
// Current steps and source codes
// ----------------------------------------------------------------
`define PAC_GAIN_STEP_UA     12'd20
`define PAC_OFFSET_STEP_UA   10'd5
`define PAC_SRC_REGDATA      5'h00
`define PAC_SRC_LOCK         5'h01

`endif

// ---- common/pac_pkg.sv ----
`default_nettype none
package pac_pkg;
  // Calibration clock divider select
  typedef enum logic [1:0] {
    PAC_DIV1  = 2'h0,
    PAC_DIV4  = 2'h1,
    PAC_DIV16 = 2'h2,
    PAC_DIV32 = 2'h3
  } pac_clkdiv_t;
  typedef logic [23:0] pac_reg_t;
endpackage
`default_nettype wire

// ---- common/pac_cal_if.sv ----
`default_nettype none
// Link between register core and calibration timer
interface pac_cal_if;
  logic       ref_tick;
  logic [1:0] clk_sel;
  logic [2:0] resolution;
  logic       fsm_tick;
  logic       interval_done;
  modport timer (input ref_tick, input clk_sel, input resolution,
                 output fsm_tick, output interval_done);
  modport core (output ref_tick, output clk_sel, output resolution,
                input fsm_tick, input interval_done);
endinterface
`default_nettype wire

// ---- rtl/pac_cal_timer.sv ----
`include "pac_defs.svh"
`default_nettype none
module pac_cal_timer
  import pac_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Link to register core
  pac_cal_if.timer  cal
);

  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic [7:0] ivl_cnt;
  logic [7:0] next_ivl_cnt;
  logic       next_fsm_tick;
  logic       next_interval_done;
  logic [4:0] div_limit;
  logic [7:0] ivl_limit;
  logic       fsm_tick_q;
  logic       done_q;

  // Divider terminal count per select code
  always_comb begin
    unique case (pac_clkdiv_t'(cal.clk_sel))
      PAC_DIV1:  div_limit = 5'h00;
      PAC_DIV4:  div_limit = 5'h03;
      PAC_DIV16: div_limit = 5'h0F;
      PAC_DIV32: div_limit = 5'h1F;
    endcase
    // Code 7 is 256 cycles, not 128; the shift alone would fall short
    if (cal.resolution == 3'h7) begin
      ivl_limit = 8'hFF;
    end else begin
      ivl_limit = 8'((9'h001 << cal.resolution) - 9'h001);
    end
  end

  // Both counters advance only on reference edges
  always_comb begin
    next_div_cnt       = div_cnt;
    next_ivl_cnt       = ivl_cnt;
    next_fsm_tick      = 1'b0;
    next_interval_done = 1'b0;
    if (cal.ref_tick) begin
      // A select change mid-count lands safely: >= restarts the count
      if (div_cnt >= div_limit) begin
        next_div_cnt  = 5'h00;
        next_fsm_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 5'h01;
      end
      if (ivl_cnt >= ivl_limit) begin
        next_ivl_cnt       = 8'h00;
        next_interval_done = 1'b1;
      end else begin
        next_ivl_cnt = ivl_cnt + 8'h01;
      end
    end
  end

  // Counter and tick registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt    <= 5'h00;
      ivl_cnt    <= 8'h00;
      fsm_tick_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      div_cnt    <= next_div_cnt;
      ivl_cnt    <= next_ivl_cnt;
      fsm_tick_q <= next_fsm_tick;
      done_q     <= next_interval_done;
    end
  end

  assign cal.fsm_tick      = fsm_tick_q;
  assign cal.interval_done = done_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fsm_tick_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    fsm_tick_q |-> $past(cal.ref_tick) && ($past(div_cnt) >= $past(div_limit)))
    else $error("calibration clock tick without divider terminal count");
  interval_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_q |-> $past(cal.ref_tick) && ($past(ivl_cnt) >= $past(ivl_limit)))
    else $error("measurement interval ended early");

endmodule
`default_nettype wire

// ---- tb/pac_host.sv ----
`include "pac_defs.svh"
`default_nettype none
// Host controller model that sits on the register bus
module pac_host (
  // Clock
  input  wire logic        pclk,
  // Bus answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // Bus request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; the request is held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Mode setup keeps the recommended settings; the device never checks them
  task automatic configure(input logic frac, input logic fast_ref);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, `PAC_ADDR_EN, {8'h00, `PAC_RST_EN} | (32'(fast_ref) << 21), r, e);
    xfer(1'b1, `PAC_ADDR_CP, {8'h00, `PAC_RST_CP & ~24'h600000} | (32'(frac) << 21), r, e);
    xfer(1'b1, `PAC_ADDR_CAL, {8'h00, `PAC_RST_CAL & ~24'h000800}, r, e);
  endtask
endmodule
`default_nettype wire

// ---- tb/pll_analog_cp_autocal_regs_bench.sv ----
`include "pac_defs.svh"
`default_nettype none
module pll_analog_cp_autocal_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, status_sources;
  logic        crystal_reference, lock_detect, serial_active, serial_addr_match;
  logic        serial_read_out, osc_reg_write, pin_o, pin_oe, bias_enable, hf_ref;
  logic [6:0]  sink, source, ofs;
  logic        ofs_up, ofs_dn, cal_disable, start, fsm_tick, done;
  logic [11:0] sink_ua, source_ua;
  logic [9:0]  ofs_ua;
  logic [2:0]  interval;
  logic [1:0]  cdiv;
  int          n_errors, comparisons, n_tick, n_done, t0, d0, dt, dd;
  logic [7:0]  adr [4] = '{`PAC_ADDR_EN, `PAC_ADDR_CP, `PAC_ADDR_CAL, `PAC_ADDR_OUT};
  logic [23:0] dft [4] = '{`PAC_RST_EN, `PAC_RST_CP, `PAC_RST_CAL, `PAC_RST_OUT};
  int          codes [3] = '{0, 1, 127};
  int          shift [4] = '{0, 2, 4, 5};

  pac_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_reference(crystal_reference), .lock_detect(lock_detect),
    .serial_active(serial_active), .serial_addr_match(serial_addr_match),
    .serial_read_out(serial_read_out), .osc_reg_write(osc_reg_write),
    .status_sources(status_sources), .shared_status_pin_o(pin_o),
    .shared_status_pin_oe(pin_oe), .bias_enable(bias_enable), .high_freq_reference(hf_ref),
    .pump_sink_gain(sink), .pump_source_gain(source), .pump_offset_mag(ofs),
    .pump_offset_up_en(ofs_up), .pump_offset_dn_en(ofs_dn), .pump_sink_ua(sink_ua),
    .pump_source_ua(source_ua), .pump_offset_ua(ofs_ua), .cal_disable(cal_disable),
    .tuning_measure_interval(interval), .oscillator_serial_link_start(start),
    .cal_fsm_tick(fsm_tick), .cal_interval_done(done));

  pac_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ----------------------------------------------------------------
  // Clock, reference and tick counters
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Reference toggles every two cycles, well below half the bus clock
  always @(posedge pclk) begin
    cdiv <= (cdiv == 2'd1) ? 2'd0 : cdiv + 2'd1;
    if (cdiv == 2'd1) crystal_reference <= ~crystal_reference;
    if (fsm_tick === 1'b1) n_tick <= n_tick + 1;
    if (done === 1'b1) n_done <= n_done + 1;
  end

  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(32'(e), 32'(err));
  endtask

  // Registered outputs are read mid-cycle, two edges after the cause
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, crystal_reference, serial_active, serial_addr_match} = 4'h0;
    {serial_read_out, osc_reg_write, cdiv} = 4'h0;
    {lock_detect, status_sources} = 33'h100000000;
    {n_errors, comparisons, n_tick, n_done} = 128'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(adr[i], {8'h00, dft[i]}, 1'b0);
    chk(32'(bias_enable), 32'd1);
    chk(32'(sink_ua), 32'd2000);
    chk(32'(source_ua), 32'd2000);
    chk(32'(ofs_ua), 32'd0);
    chk(32'(interval), 32'd5);
    chk(32'({pin_oe, pin_o}), 32'd3);
    // Pattern through every register, upper byte must be dropped
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 32'hFFA5A5A5);
      rd(adr[i], 32'h00A5A5A5, 1'b0);
      wr(adr[i], {8'h00, dft[i]});
    end
    wr(8'h30, 32'h00000123);
    rd(8'h30, 32'h0, 1'b1);
    // Current decodes at both ends and the first step
    for (int i = 0; i < 3; i++) begin
      wr(`PAC_ADDR_CP, 32'(codes[i] | (codes[i] << 7) | (codes[i] << 14)));
      settle();
      chk(32'({sink, source, ofs}), 32'(codes[i] * 16'h4081));
      chk(32'(sink_ua), 32'(codes[i] * 20));
      chk(32'(source_ua), 32'(codes[i] * 20));
      chk(32'(ofs_ua), 32'(codes[i] * 5));
    end
    host.configure(1'b1, 1'b1);
    settle();
    chk(32'({hf_ref, ofs_up, ofs_dn, cal_disable}), 32'hC);
    host.configure(1'b0, 1'b0);
    settle();
    chk(32'({hf_ref, ofs_up, ofs_dn}), 32'h0);
    // Shared pin: always-drive, pad off, shared bus release
    @(posedge pclk) serial_active <= 1'b1;
    wr(`PAC_ADDR_OUT, 32'h000000A0);
    settle();
    chk(32'({pin_oe, pin_o}), 32'd3);
    wr(`PAC_ADDR_EN, {8'h00, `PAC_RST_EN & ~24'h000020});
    settle();
    chk(32'(pin_oe), 32'd0);
    wr(`PAC_ADDR_EN, {8'h00, `PAC_RST_EN});
    wr(`PAC_ADDR_OUT, 32'h00000003);
    settle();
    chk(32'(pin_oe), 32'd0);
    @(posedge pclk) {serial_addr_match, serial_read_out} <= 2'b11;
    settle();
    chk(32'({pin_oe, pin_o}), 32'd3);
    @(posedge pclk) {serial_active, status_sources} <= {1'b0, 32'h00000008};
    settle();
    chk(32'({pin_oe, pin_o}), 32'd3);
    @(posedge pclk) status_sources <= 32'h0;
    settle();
    chk(32'(pin_o), 32'd0);
    wr(`PAC_ADDR_OUT, 32'h00000001);
    @(posedge pclk) status_sources <= 32'hFFFFFFFF;
    lock_detect <= 1'b0;
    repeat (5) @(negedge pclk);
    chk(32'(pin_o), 32'd0);
    // Oscillator link start, blocked and not
    for (int b = 0; b < 2; b++) begin
      wr(`PAC_ADDR_CAL, {8'h00, `PAC_RST_CAL} | 32'(b << 12));
      @(posedge pclk) osc_reg_write <= 1'b1;
      @(posedge pclk) osc_reg_write <= 1'b0;
      @(negedge pclk);
      chk(32'(start), 32'(1 - b));
      @(negedge pclk);
      chk(32'(start), 32'd0);
    end
    // Divider and interval over 160 reference rises, one tick of slack
    for (int k = 0; k < 4; k++) begin
      wr(`PAC_ADDR_CAL, {8'h00, `PAC_RST_CAL & ~24'h006007} | 32'((k << 13) | k));
      repeat (80) @(posedge pclk);
      {t0, d0} = {n_tick, n_done};
      repeat (640) @(posedge pclk);
      dt = n_tick - t0 - (160 >> shift[k]);
      dd = n_done - d0 - (160 >> k);
      chk(32'(dt * dt <= 1), 32'd1);
      chk(32'(dd * dd <= 1), 32'd1);
    end
    // Longest interval: 512 reference rises hold two intervals of 256
    wr(`PAC_ADDR_CAL, {8'h00, `PAC_RST_CAL | 24'h000007});
    repeat (80) @(posedge pclk);
    d0 = n_done;
    repeat (2048) @(posedge pclk);
    dd = n_done - d0 - 2;
    chk(32'(dd * dd <= 1), 32'd1);
    // Second reset in mid-run brings defaults back
    wr(`PAC_ADDR_CP, 32'h00FFFFFF);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PAC_ADDR_CP, {8'h00, `PAC_RST_CP}, 1'b0);
    chk(32'(sink_ua), 32'd2000);
    finish_test();
  end
endmodule
`default_nettype wire
